// ### logic/pie_pkg.sv
// Constants and register layout of the peripheral interrupt enable bank.
// Assumes a single 100 MHz clock domain and an AXI4-Lite master on the register side.
// Operation
// R1: Enable bank is 32-bit RW at 14h
// R2: Endpoints 1-7 TX/RX enables, bits 12-25
// R3: Bit 11 gates control IN interrupts
// R4: Bit 10 gates control OUT interrupts
// R5: Bit 8 gates setup packet interrupt
// R6: Bit 7 gates supply polarity change
// R7: Bit 6 gates DMA status change
// R8: Bit 5 gates high-speed status change
// R9: Bit 4 gates resume detection interrupt
// R10: Bit 3 gates suspend detection interrupt
// R11: Bit 2 gates pseudo frame interrupt
// R12: Bit 1 gates frame start interrupt
// R13: Bit 0 gates bus reset interrupt
// R14: Software writes unused bits as zero
// R15: Bus reset clears all enables except bit 0
// R16: Global enable suppresses every interrupt; here it only blocks new events, and status already latched still drives IRQ
// R17: Power-on clears; forward only enabled events
package pie_pkg;

  // Register byte offsets
  localparam logic [7:0]  OFS_MODE    = 8'h0C; // Global enable register
  localparam logic [7:0]  OFS_ENABLE  = 8'h14; // Enable bank
  localparam logic [7:0]  OFS_STATUS  = 8'h18; // Sticky status, clear on read
  localparam logic [7:0]  OFS_MASK    = 8'h1C; // Output mask

  // Field positions
  localparam int          BIT_BUS_RST = 0;     // Bus reset enable
  localparam int          BIT_FRAME   = 1;     // Frame start enable
  localparam int          BIT_PSOF    = 2;     // Pseudo frame enable
  localparam int          BIT_SUSP    = 3;     // Suspend enable
  localparam int          BIT_RESUME  = 4;     // Resume enable
  localparam int          BIT_SPEED   = 5;     // Speed change enable
  localparam int          BIT_DMA     = 6;     // DMA change enable
  localparam int          BIT_SUPPLY  = 7;     // Supply sense enable
  localparam int          BIT_SETUP   = 8;     // Setup packet enable
  localparam int          BIT_CTL_OUT = 10;    // Control OUT enable
  localparam int          BIT_CTL_IN  = 11;    // Control IN enable
  localparam int          BIT_EP_BASE = 12;    // Endpoint 1 RX; TX one above
  localparam int          BIT_GLOBAL  = 0;     // Global enable in mode register

  // Writable bits: 31..26 and 9 are unused
  localparam logic [31:0] ENABLE_WMASK = 32'h03FF_FDFF;
  // Bits that survive a USB bus reset
  localparam logic [31:0] BUS_RST_KEEP = 32'h0000_0001;
  // Reset values
  localparam logic [31:0] ENABLE_RST   = 32'h0000_0000;
  localparam logic [31:0] MASK_RST     = 32'hFFFF_FFFF;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage : pie_pkg

// ### logic/pie_evt_if.sv
// Event path between the enable bank and its gating stage.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface pie_evt_if;
  logic [31:0] raw;     // Source event pulses
  logic [31:0] enable;  // Per-source enables
  logic        global_irq_en; // Global enable
  logic [31:0] gated;   // Forwarded requests

  modport bank (output raw, output enable, output global_irq_en, input gated);
  modport gate (input raw, input enable, input global_irq_en, output gated);
endinterface : pie_evt_if

// ### logic/pie_gate.sv
// Gating stage: forwards a source event only when enabled.
// Assumes events are same-clock pulses from the core.
`timescale 1ns/100ps
module pie_gate (
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic SYS_RST,
  // Event path
  pie_evt_if.gate   evt
);

  typedef struct packed {
    logic [31:0] gated; // Registered requests
  } pie_gate_s;

  pie_gate_s st_q;  // State
  pie_gate_s st_d;  // Next state

  // Enable bit and global enable must both be set
  always_comb begin
    st_d       = st_q;
    st_d.gated = evt.global_irq_en ? (evt.raw & evt.enable) : 32'h0000_0000; // [R16] [R17]
  end

  // Register the requests
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign evt.gated = st_q.gated;

endmodule : pie_gate

// ### logic/pie_top.sv
// Peripheral interrupt enable bank with AXI4-Lite register access.
// Assumes event inputs are single-cycle pulses on CLOCK.
`timescale 1ns/100ps
module pie_top (
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        SYS_RST,
  // Endpoint events, bit n = endpoint n
  input  wire logic [7:0]  EP_TX_EVT,
  input  wire logic [7:0]  EP_RX_EVT,
  // Link events
  input  wire logic        SETUP_EVT,
  input  wire logic        SUPPLY_EVT,
  input  wire logic        DMA_EVT,
  input  wire logic        SPEED_EVT,
  input  wire logic        RESUME_EVT,
  input  wire logic        SUSPEND_EVT,
  input  wire logic        PSOF_EVT,
  input  wire logic        FRAME_EVT,
  input  wire logic        BUS_RST_EVT,
  // AXI4-Lite write
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Interrupt request
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic        aw_full;  // Write address held
    logic [7:0]  aw_addr;  // Held write address
    logic        w_full;   // Write data held
    logic [31:0] w_data;   // Held write data
    logic [3:0]  w_strb;   // Held strobes
    logic        bvalid;   // Write response pending
    logic [1:0]  bresp;    // Write response code
    logic        rvalid;   // Read data pending
    logic [31:0] rdata;    // Read data
    logic [1:0]  rresp;    // Read response code
    logic [31:0] enable;   // Enable bank
    logic        global_irq_en; // Global enable
    logic        aw_rdy;   // Address channel open
    logic        w_rdy;    // Data channel open
    logic        ar_rdy;   // Read address channel open
    logic [31:0] status;   // Sticky forwarded events
    logic [31:0] mask;     // Interrupt output mask
    logic        irq;      // Registered interrupt
  } pie_top_s;

  pie_top_s    st_q;       // State
  pie_top_s    st_d;       // Next state
  logic [31:0] raw_evt;    // Events in bank layout

  pie_evt_if   evt ();     // Path to gating stage

  ////////////////////////////////////////////////////////////////////////////
  // Event layout

  // Endpoints 1..7 pair up RX below TX
  genvar g;
  generate
    for (g = 1; g < 8; g++) begin : g_ep
      assign raw_evt[pie_pkg::BIT_EP_BASE + 2*(g-1)]     = EP_RX_EVT[g]; // [R2]
      assign raw_evt[pie_pkg::BIT_EP_BASE + 2*(g-1) + 1] = EP_TX_EVT[g]; // [R2]
    end
  endgenerate

  // Fixed sources at their enable positions
  assign raw_evt[pie_pkg::BIT_CTL_IN]  = EP_TX_EVT[0]; // [R3]
  assign raw_evt[pie_pkg::BIT_CTL_OUT] = EP_RX_EVT[0]; // [R4]
  assign raw_evt[pie_pkg::BIT_SETUP]   = SETUP_EVT;    // [R5]
  assign raw_evt[pie_pkg::BIT_SUPPLY]  = SUPPLY_EVT;   // [R6]
  assign raw_evt[pie_pkg::BIT_DMA]     = DMA_EVT;      // [R7]
  assign raw_evt[pie_pkg::BIT_SPEED]   = SPEED_EVT;    // [R8]
  assign raw_evt[pie_pkg::BIT_RESUME]  = RESUME_EVT;   // [R9]
  assign raw_evt[pie_pkg::BIT_SUSP]    = SUSPEND_EVT;  // [R10]
  assign raw_evt[pie_pkg::BIT_PSOF]    = PSOF_EVT;     // [R11]
  assign raw_evt[pie_pkg::BIT_FRAME]   = FRAME_EVT;    // [R12]
  assign raw_evt[pie_pkg::BIT_BUS_RST] = BUS_RST_EVT;  // [R13]
  // Unused positions never fire
  assign raw_evt[9]     = 1'b0;
  assign raw_evt[31:26] = 6'h00;

  // Feed the gating stage
  assign evt.raw    = raw_evt;
  assign evt.enable = st_q.enable;
  assign evt.global_irq_en = st_q.global_irq_en;

  pie_gate u_gate (
    .CLOCK   (CLOCK),
    .SYS_RST (SYS_RST),
    .evt     (evt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic        do_wr;    // Write commits this cycle
    logic [31:0] wmask;    // Byte-lane mask
    logic [31:0] wval;     // Merged write value
    logic        clr_stat; // Status read clears
    do_wr    = 1'b0;
    wmask    = 32'h0000_0000;
    wval     = 32'h0000_0000;
    clr_stat = 1'b0;
    st_d     = st_q;

    // Capture write address and data in either order
    if (S_AXI_AWVALID && !st_q.aw_full) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st_q.w_full) begin
      st_d.w_full = 1'b1;
      st_d.w_data = S_AXI_WDATA;
      st_d.w_strb = S_AXI_WSTRB;
    end

    // Response released
    if (st_q.bvalid && S_AXI_BREADY) begin
      st_d.bvalid = 1'b0;
    end

    // Commit once both halves are held and no response is pending
    if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
      do_wr        = 1'b1;
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = pie_pkg::RESP_OKAY;
      for (int i = 0; i < 4; i++) begin
        wmask[8*i +: 8] = {8{st_q.w_strb[i]}};
      end
    end

    if (do_wr) begin
      unique case (st_q.aw_addr)
        pie_pkg::OFS_ENABLE: begin
          // Unused bits stay zero regardless of software
          wval        = (st_q.enable & ~wmask) | (st_q.w_data & wmask); // [R1] [R14]
          st_d.enable = wval & pie_pkg::ENABLE_WMASK;
        end
        pie_pkg::OFS_MODE: begin
          if (st_q.w_strb[0]) begin
            st_d.global_irq_en = st_q.w_data[pie_pkg::BIT_GLOBAL]; // [R16]
          end
        end
        pie_pkg::OFS_MASK: begin
          st_d.mask = (st_q.mask & ~wmask) | (st_q.w_data & wmask);
        end
        pie_pkg::OFS_STATUS: begin
          // Status clears only by reading; writes ignored
        end
        default: begin
          st_d.bresp = pie_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Read path, one outstanding
    if (st_q.rvalid && S_AXI_RREADY) begin
      st_d.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && !st_q.rvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = pie_pkg::RESP_OKAY;
      unique case (S_AXI_ARADDR)
        pie_pkg::OFS_ENABLE: st_d.rdata = st_q.enable; // [R1]
        pie_pkg::OFS_MODE:   st_d.rdata = {31'h0000_0000, st_q.global_irq_en};
        pie_pkg::OFS_STATUS: begin
          st_d.rdata = st_q.status;
          clr_stat   = 1'b1;
        end
        pie_pkg::OFS_MASK:   st_d.rdata = st_q.mask;
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = pie_pkg::RESP_SLVERR;
        end
      endcase
    end

    // A USB bus reset wipes every enable except its own; wins over a write
    if (BUS_RST_EVT) begin
      st_d.enable = st_d.enable & pie_pkg::BUS_RST_KEEP; // [R15]
    end

    // Sticky status: new event wins over the read clear
    st_d.status = (clr_stat ? 32'h0000_0000 : st_q.status) | evt.gated; // [R17]

    // Level output while any unmasked status bit stands
    st_d.irq = |(st_d.status & st_d.mask);

    // Readies as flops, in step with the hold flags they mirror
    st_d.aw_rdy = !st_d.aw_full;
    st_d.w_rdy  = !st_d.w_full;
    st_d.ar_rdy = !st_d.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Power-on clears everything but the mask and the three readies
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st_q        <= '0;
      st_q.enable <= pie_pkg::ENABLE_RST; // [R17]
      st_q.mask   <= pie_pkg::MASK_RST;
      st_q.aw_rdy <= 1'b1;
      st_q.w_rdy  <= 1'b1;
      st_q.ar_rdy <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops

  assign S_AXI_AWREADY = st_q.aw_rdy;
  assign S_AXI_WREADY  = st_q.w_rdy;
  assign S_AXI_BVALID  = st_q.bvalid;
  assign S_AXI_BRESP   = st_q.bresp;
  assign S_AXI_ARREADY = st_q.ar_rdy;
  assign S_AXI_RVALID  = st_q.rvalid;
  assign S_AXI_RDATA   = st_q.rdata;
  assign S_AXI_RRESP   = st_q.rresp;
  assign IRQ           = st_q.irq;

endmodule : pie_top

// ### verif/pie_chk.sv
// Port checker for pie_top: bus handshakes and the interrupt line.
// Bound to every pie_top instance; one clock domain.
`timescale 1ns/100ps
module pie_chk (
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        SYS_RST,
  // Write side
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  // Read side
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  // Interrupt
  input wire logic        IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  logic [7:0] ra_q; // Register of the read in flight
  ////////////////////////////////
  // Remember the read address for the answer
  always_ff @(posedge CLOCK) begin
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      ra_q <= S_AXI_ARADDR;
    end
  end
  ////////////////////////////////
  a_wr_answer_time: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer not on time");
  a_rd_answer_time: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read answer not on time");
  a_bresp_stands: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write answer dropped");
  a_rdata_stands: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped");
  a_ar_refused: assert property (
    S_AXI_RVALID |-> !S_AXI_ARREADY) else $error("address taken during answer");
  a_unused_zero: assert property (
    S_AXI_RVALID && ra_q == pie_pkg::OFS_ENABLE |-> (S_AXI_RDATA & ~pie_pkg::ENABLE_WMASK) == 32'h0)
    else $error("unused enable bits read set");
  a_reset_idle: assert property (@(posedge CLOCK) disable iff (1'b0)
    SYS_RST |=> !S_AXI_BVALID && !S_AXI_RVALID && !IRQ) else $error("outputs busy after reset");
  a_irq_quiet: assert property (
    $fell(SYS_RST) |-> !IRQ ##1 !IRQ) else $error("request without event");
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
  c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
  c_irq: cover property ($rose(IRQ));
endmodule : pie_chk

bind pie_top pie_chk i_chk (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .IRQ(IRQ));

// ### verif/pie_host.sv
// Processor model: AXI4-Lite master with one write and one read task.
// Tasks are entered just after a rising edge; hung flags a lost answer.
`timescale 1ns/100ps
module pie_host (
  // Clock
  input wire logic         CLOCK,
  // Write channels
  output logic [7:0]       aw_addr,
  output logic             aw_v,
  input wire logic         aw_r,
  output logic [31:0]      w_data,
  output logic             w_v,
  input wire logic         w_r,
  input wire logic [1:0]   b_resp,
  input wire logic         b_v,
  output logic             b_r,
  // Read channels
  output logic [7:0]       ar_addr,
  output logic             ar_v,
  input wire logic         ar_r,
  input wire logic [31:0]  r_data,
  input wire logic [1:0]   r_resp,
  input wire logic         r_v,
  output logic             r_r,
  // Status
  output logic             hung
);
  // Quiet bus at time zero
  initial begin
    {aw_addr, aw_v, w_data, w_v, b_r, ar_addr, ar_v, r_r, hung} = '0;
  end
  ////////////////////////////////
  // One write; both halves offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    aw_addr <= a;
    w_data  <= d; // callers leave unused bits at zero
    aw_v    <= 1'b1;
    w_v     <= 1'b1;
    b_r     <= 1'b1;
    while ((aw_v || w_v || !b_v) && n < 50) begin
      @(posedge CLOCK);
      n++;
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
    end
    rs = b_resp;
    b_r <= 1'b0;
    if (n >= 50) hung <= 1'b1;
    @(posedge CLOCK);
  endtask : wr
  // One read; rready held until the answer
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    ar_addr <= a;
    ar_v    <= 1'b1;
    r_r     <= 1'b1;
    while ((ar_v || !r_v) && n < 50) begin
      @(posedge CLOCK);
      n++;
      if (ar_v && ar_r) ar_v <= 1'b0;
    end
    d = r_data;
    rs = r_resp;
    r_r <= 1'b0;
    if (n >= 50) hung <= 1'b1;
    @(posedge CLOCK);
  endtask : rd
endmodule : pie_host

// ### verif/peripheral_interrupt_enable_tb.sv
// Testbench for pie_top: registers, gating, bus reset and interrupt line.
// Events are driven here in enable-bit layout; pie_host drives the bus.
`timescale 1ns/100ps
module peripheral_interrupt_enable_tb;
  logic clock, sys_rst, hung;           // Clock, reset, lost answer
  logic [31:0] ev;                       // Events, one per enable bit
  logic [7:0] tx, rx;                    // Endpoint events
  logic [7:0] aw_addr, ar_addr;          // Bus addresses
  logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, irq;
  logic [31:0] w_data, r_data, d;        // Bus data
  logic [1:0] b_resp, r_resp, rs;        // Responses
  int bad_count, tests_run;
  always #5 clock = ~clock;
  // Endpoint n: transmit at bit 11+2n, receive at 10+2n
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      tx[n] = ev[11 + 2 * n];
      rx[n] = ev[10 + 2 * n];
    end
  end
  pie_host i_host (.CLOCK(clock), .aw_addr(aw_addr), .aw_v(aw_v), .aw_r(aw_r), .w_data(w_data), .w_v(w_v),
    .w_r(w_r), .b_resp(b_resp), .b_v(b_v), .b_r(b_r), .ar_addr(ar_addr), .ar_v(ar_v), .ar_r(ar_r),
    .r_data(r_data), .r_resp(r_resp), .r_v(r_v), .r_r(r_r), .hung(hung));
  pie_top i_dut (.CLOCK(clock), .SYS_RST(sys_rst), .EP_TX_EVT(tx), .EP_RX_EVT(rx), .SETUP_EVT(ev[8]),
    .SUPPLY_EVT(ev[7]), .DMA_EVT(ev[6]), .SPEED_EVT(ev[5]), .RESUME_EVT(ev[4]), .SUSPEND_EVT(ev[3]),
    .PSOF_EVT(ev[2]), .FRAME_EVT(ev[1]), .BUS_RST_EVT(ev[0]), .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_v),
    .S_AXI_AWREADY(aw_r), .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(w_r),
    .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r), .S_AXI_ARADDR(ar_addr),
    .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_r), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
    .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .IRQ(irq));
  ////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Read and compare data and response
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    i_host.rd(a, d, rs);
    chk("read data", e, d);
    chk("read resp", {30'h0, er}, {30'h0, rs});
  endtask : rchk
  task automatic wchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    i_host.wr(a, v, rs);
    chk("write resp", {30'h0, er}, {30'h0, rs});
  endtask : wchk
  // One-cycle event pulse, then let it reach status
  task automatic pulse(input logic [31:0] v);
    ev <= v;
    @(posedge clock);
    ev <= 32'h0;
    repeat (4) @(posedge clock);
  endtask : pulse
  ////////////////////////////////
  task automatic t_reset;
    rchk(pie_pkg::OFS_ENABLE, 32'h0, pie_pkg::RESP_OKAY);
    rchk(pie_pkg::OFS_MODE, 32'h0, pie_pkg::RESP_OKAY);
    rchk(pie_pkg::OFS_MASK, 32'hFFFF_FFFF, pie_pkg::RESP_OKAY);
    rchk(pie_pkg::OFS_STATUS, 32'h0, pie_pkg::RESP_OKAY);
  endtask : t_reset
  // Alternating patterns over every used bit, plus an unmapped place
  task automatic t_rw;
    wchk(pie_pkg::OFS_ENABLE, 32'h0155_5555, pie_pkg::RESP_OKAY);
    rchk(pie_pkg::OFS_ENABLE, 32'h0155_5555, pie_pkg::RESP_OKAY);
    wchk(pie_pkg::OFS_ENABLE, 32'h02AA_A8AA, pie_pkg::RESP_OKAY);
    rchk(pie_pkg::OFS_ENABLE, 32'h02AA_A8AA, pie_pkg::RESP_OKAY);
    wchk(8'h40, 32'h1, pie_pkg::RESP_SLVERR);
    rchk(8'h40, 32'h0, pie_pkg::RESP_SLVERR);
  endtask : t_rw
  // Global enable off, then on; mask and clear-on-read of the line
  task automatic t_global;
    wchk(pie_pkg::OFS_ENABLE, 32'h03FF_FDFF, pie_pkg::RESP_OKAY);
    pulse(32'h03FF_FDFE);
    chk("irq off", 32'h0, {31'h0, irq});
    rchk(pie_pkg::OFS_STATUS, 32'h0, pie_pkg::RESP_OKAY);
    wchk(pie_pkg::OFS_MODE, 32'h1, pie_pkg::RESP_OKAY);
    pulse(32'h03FF_FDFE);
    chk("irq on", 32'h1, {31'h0, irq});
    wchk(pie_pkg::OFS_MASK, 32'h0, pie_pkg::RESP_OKAY);
    chk("irq masked", 32'h0, {31'h0, irq});
    wchk(pie_pkg::OFS_MASK, 32'hFFFF_FFFF, pie_pkg::RESP_OKAY);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    rchk(pie_pkg::OFS_STATUS, 32'h03FF_FDFE, pie_pkg::RESP_OKAY);
    repeat (2) @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : t_global
  // One enable at a time against all events, bus reset among them
  task automatic t_gate;
    for (int b = 0; b < 26; b++) begin
      if (b != 9) begin
        wchk(pie_pkg::OFS_ENABLE, 32'h1 << b, pie_pkg::RESP_OKAY);
        pulse(32'h03FF_FDFF);
        rchk(pie_pkg::OFS_STATUS, 32'h1 << b, pie_pkg::RESP_OKAY);
        rchk(pie_pkg::OFS_ENABLE, (b == 0) ? 32'h1 : 32'h0, pie_pkg::RESP_OKAY);
      end
    end
  endtask : t_gate
  ////////////////////////////////
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Lost bus answer ends the run
  always @(posedge hung) begin
    bad_count++;
    report_and_stop();
  end
  initial begin
    {clock, ev, bad_count, tests_run} = '0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_rw();
    t_global();
    t_gate();
    report_and_stop();
  end
endmodule : peripheral_interrupt_enable_tb
